// ===== rtl/ccrb_pkg.sv
// Package: constants, field positions and types of the core configuration register bank
package ccrb_pkg;

   // Register numbers as software sees them (after the half swap)
   localparam logic [9:0] CCRB_NUM_LOOP_COUNT = 10'h009;
   localparam logic [9:0] CCRB_NUM_TB_LOW = 10'h10C;
   localparam logic [9:0] CCRB_NUM_TB_HIGH = 10'h10D;
   localparam logic [9:0] CCRB_NUM_CORE_CFG = 10'h3B3;

   // Configuration fields, as LSB-0 positions of big-endian bits 6..31
   localparam int CCRB_LOAD_FULL_LINE_POS = 25;
   localparam int CCRB_LOAD_NO_ALLOC_POS = 24;
   localparam int CCRB_STORE_NO_ALLOC_POS = 23;
   localparam int CCRB_DATA_PRIO1_POS = 22;
   localparam int CCRB_INSTR_PRIO_HI_POS = 21;
   localparam int CCRB_INSTR_PRIO_LO_POS = 20;
   localparam int CCRB_USER_ATTR_EXC_POS = 17;
   localparam int CCRB_LOAD_DEBUG_POS = 16;
   localparam int CCRB_PREFETCH_CACH_POS = 11;
   localparam int CCRB_PREFETCH_NONCACH_POS = 10;
   localparam int CCRB_NC_FETCH_SIZE_POS = 9;
   localparam int CCRB_FETCH_NO_ALLOC_POS = 8;
   localparam int CCRB_CACHE_INFO_POS = 4;
   localparam int CCRB_CACHE_WAY_POS = 0;

   // Writable configuration bits; everything else reads zero
   localparam logic [31:0] CCRB_CFG_WRITE_MASK = 32'h03F30F11;

   localparam logic [31:0] CCRB_CFG_RESET = 32'h00000000;
   localparam logic [31:0] CCRB_COND_RESET = 32'h00000000;
   localparam logic [31:0] CCRB_COUNT_RESET = 32'h00000000;

   localparam int CCRB_COND_FIELDS = 8;
   localparam int CCRB_COND_FIELD_W = 4;

   typedef enum logic [2:0] {
      CCRB_OP_NONE = 3'h0,
      CCRB_OP_MOVE_TO_SPECIAL = 3'h1,
      CCRB_OP_MOVE_FROM_SPECIAL = 3'h2,
      CCRB_OP_MOVE_FROM_TB = 3'h3,
      CCRB_OP_MOVE_TO_DEVICE = 3'h4,
      CCRB_OP_MOVE_FROM_DEVICE = 3'h5,
      CCRB_OP_MOVE_TO_COND = 3'h6,
      CCRB_OP_MOVE_FROM_COND = 3'h7
   } ccrb_op_type;

   // Instruction field carries the two five-bit halves reversed
   function automatic logic [9:0] ccrb_swap_halves(input logic [9:0] fld);
      return {fld[4:0], fld[9:5]};
   endfunction

endpackage

// ===== rtl/ccrb_num_decode.sv
// Register number decoder: swaps the encoded halves and classifies the number
`timescale 1ns/1ps
`default_nettype none
module ccrb_num_decode
   import ccrb_pkg::*;
(
   input wire logic [9:0] reg_field,
   output logic [9:0] reg_number,
   output logic hit_loop_count,
   output logic hit_core_cfg,
   output logic hit_tb_low,
   output logic hit_tb_high
);
   always_comb begin
      reg_number = ccrb_swap_halves(reg_field); // RULE_04
      hit_loop_count = (reg_number == CCRB_NUM_LOOP_COUNT);
      hit_core_cfg = (reg_number == CCRB_NUM_CORE_CFG);
      hit_tb_low = (reg_number == CCRB_NUM_TB_LOW); // RULE_03
      hit_tb_high = (reg_number == CCRB_NUM_TB_HIGH); // RULE_03
   end
endmodule // ccrb_num_decode
`default_nettype wire

// ===== rtl/ccrb_core_config_bank.sv
// Core configuration register bank: configuration, condition, count and time base view
//
// Contract
// RULE_01 - 64-bit time base is seen as two 32-bit halves, low and high.
// RULE_02 - User mode may read time base halves; that path never writes.
// RULE_03 - Time-base numbers 0x10C low half, 0x10D high half, read-only.
// RULE_04 - Register number field halves are swapped; 0x188 and 0x1A8 select halves.
// RULE_05 - Device control moves are privileged for every number; software avoids absent ones.
// RULE_06 - Config bit 6 set: data loads fetch eight words into fill buffer.
// RULE_07 - Config bit 7 set: load misses are non-cachable, no allocate.
// RULE_08 - Config bit 8 set: store misses are non-cachable, no allocate.
// RULE_09 - Config bit 9 is data priority bit 1; bit 0 is dynamic.
// RULE_10 - Config bits 10:11 give instruction cache priority, 00 lowest.
// RULE_11 - Config bit 14 enables the user storage attribute exception.
// RULE_12 - Config bit 15 makes load data visible on on-chip memory interface.
// RULE_13 - Config bit 20 enables prefetch for cachable regions.
// RULE_14 - Config bit 21 enables prefetch for non-cachable regions.
// RULE_15 - Config bit 22 selects eight-word non-cachable fetches, else four.
// RULE_16 - Config bit 23 set: instruction misses fetch without line fill.
// RULE_17 - Config bit 27 selects tag versus data; bit 31 selects way.
// RULE_18 - Condition register is eight four-bit fields, field 0 at bits 0:3.
// RULE_19 - Count register uses all 32 bits for count or branch target.
// RULE_20 - Reserved configuration bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module ccrb_core_config_bank
   import ccrb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire ccrb_op_type op_kind,
   input wire logic user_mode,
   input wire logic [9:0] reg_field,
   input wire logic [31:0] wr_data,
   input wire logic [7:0] cond_field_mask,
   input wire logic [63:0] time_base,
   input wire logic [31:0] dcr_rd_data,
   input wire logic loop_dec,
   input wire logic data_prio_dyn,
   output logic resp_valid,
   output logic [31:0] resp_data,
   output logic resp_priv_fault,
   output logic resp_bad_number,
   output logic dcr_req,
   output logic dcr_write,
   output logic [9:0] dcr_number,
   output logic [31:0] dcr_wdata,
   output logic [31:0] core_configuration,
   output logic load_full_line,
   output logic load_no_allocate,
   output logic store_no_allocate,
   output logic [1:0] data_bus_priority,
   output logic [1:0] instr_bus_priority,
   output logic user_attr_exception_enable,
   output logic load_debug_visible,
   output logic prefetch_cachable,
   output logic prefetch_noncachable,
   output logic noncachable_fetch_size,
   output logic fetch_no_allocate,
   output logic cache_info_select,
   output logic cache_way_select,
   output logic [31:0] condition_fields,
   output logic [31:0] loop_count
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   logic [9:0] reg_number;
   logic hit_loop_count;
   logic hit_core_cfg;
   logic hit_tb_low;
   logic hit_tb_high;
   logic [31:0] cfg_reg;
   logic [31:0] cond_reg;
   logic [31:0] count_reg;
   logic [1:0] data_prio_reg;
   logic cfg_write;
   logic count_write;
   logic cond_write;

   ccrb_num_decode ccrb_num_decode_i ( // RULE_04
      .reg_field(reg_field),
      .reg_number(reg_number),
      .hit_loop_count(hit_loop_count),
      .hit_core_cfg(hit_core_cfg),
      .hit_tb_low(hit_tb_low),
      .hit_tb_high(hit_tb_high)
   );

   // Configuration is privileged; count is open to user mode
   assign cfg_write = op_valid && op_kind == CCRB_OP_MOVE_TO_SPECIAL && hit_core_cfg && !user_mode;
   assign count_write = op_valid && op_kind == CCRB_OP_MOVE_TO_SPECIAL && hit_loop_count;
   assign cond_write = op_valid && op_kind == CCRB_OP_MOVE_TO_COND;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration register

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_reg <= CCRB_CFG_RESET;
      end else if (cfg_write) begin
         cfg_reg <= wr_data & CCRB_CFG_WRITE_MASK; // RULE_20
      end
   end

   assign core_configuration = cfg_reg;
   assign load_full_line = cfg_reg[CCRB_LOAD_FULL_LINE_POS]; // RULE_06
   assign load_no_allocate = cfg_reg[CCRB_LOAD_NO_ALLOC_POS]; // RULE_07
   assign store_no_allocate = cfg_reg[CCRB_STORE_NO_ALLOC_POS]; // RULE_08
   // Big-endian bit 10 is the priority MSB
   assign instr_bus_priority = {cfg_reg[CCRB_INSTR_PRIO_HI_POS], cfg_reg[CCRB_INSTR_PRIO_LO_POS]}; // RULE_10
   assign user_attr_exception_enable = cfg_reg[CCRB_USER_ATTR_EXC_POS]; // RULE_11
   assign load_debug_visible = cfg_reg[CCRB_LOAD_DEBUG_POS]; // RULE_12
   assign prefetch_cachable = cfg_reg[CCRB_PREFETCH_CACH_POS]; // RULE_13
   assign prefetch_noncachable = cfg_reg[CCRB_PREFETCH_NONCACH_POS]; // RULE_14
   assign noncachable_fetch_size = cfg_reg[CCRB_NC_FETCH_SIZE_POS]; // RULE_15
   assign fetch_no_allocate = cfg_reg[CCRB_FETCH_NO_ALLOC_POS]; // RULE_16
   assign cache_info_select = cfg_reg[CCRB_CACHE_INFO_POS]; // RULE_17
   assign cache_way_select = cfg_reg[CCRB_CACHE_WAY_POS]; // RULE_17

   // Bit 0 tracks the data cache logic, registered so the port comes from a flop
   always_ff @(posedge core_clk) begin
      if (rst) begin
         data_prio_reg <= 2'h0;
      end else begin
         data_prio_reg <= {cfg_reg[CCRB_DATA_PRIO1_POS], data_prio_dyn}; // RULE_09
      end
   end

   assign data_bus_priority = data_prio_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Condition fields, field 0 in the most significant nibble

   genvar gi;
   generate
      for (gi = 0; gi < CCRB_COND_FIELDS; gi++) begin : g_cond
         localparam int LSB = 28 - CCRB_COND_FIELD_W * gi;
         always_ff @(posedge core_clk) begin
            if (rst) begin
               cond_reg[LSB +: CCRB_COND_FIELD_W] <= CCRB_COND_RESET[LSB +: CCRB_COND_FIELD_W];
            end else if (cond_write && cond_field_mask[gi]) begin
               cond_reg[LSB +: CCRB_COND_FIELD_W] <= wr_data[LSB +: CCRB_COND_FIELD_W]; // RULE_18
            end
         end
      end
   endgenerate

   assign condition_fields = cond_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Count register; a software write wins over a same-cycle decrement

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= CCRB_COUNT_RESET;
      end else if (count_write) begin
         count_reg <= wr_data; // RULE_19
      end else if (loop_dec) begin
         count_reg <= count_reg - 32'h00000001; // RULE_19
      end
   end

   assign loop_count = count_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Answer path: one-cycle pulse after each request

   always_ff @(posedge core_clk) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp_data <= 32'h00000000;
         resp_priv_fault <= 1'b0;
         resp_bad_number <= 1'b0;
      end else begin
         resp_valid <= op_valid && op_kind != CCRB_OP_NONE;
         resp_data <= 32'h00000000;
         resp_priv_fault <= 1'b0;
         resp_bad_number <= 1'b0;
         if (op_valid) begin
            case (op_kind)
               CCRB_OP_MOVE_FROM_TB: begin
                  // Time base read path is open to user mode and never writes
                  if (hit_tb_low) begin
                     resp_data <= time_base[31:0]; // RULE_01 RULE_02 RULE_03
                  end else if (hit_tb_high) begin
                     resp_data <= time_base[63:32]; // RULE_01 RULE_02 RULE_03
                  end else begin
                     resp_bad_number <= 1'b1;
                  end
               end
               CCRB_OP_MOVE_FROM_SPECIAL: begin
                  if (hit_loop_count) begin
                     resp_data <= count_reg;
                  end else if (hit_core_cfg) begin
                     resp_priv_fault <= user_mode;
                     resp_data <= user_mode ? 32'h00000000 : cfg_reg;
                  end else begin
                     resp_bad_number <= 1'b1;
                  end
               end
               CCRB_OP_MOVE_TO_SPECIAL: begin
                  if (hit_core_cfg) begin
                     resp_priv_fault <= user_mode;
                  end else if (!hit_loop_count) begin
                     resp_bad_number <= 1'b1;
                  end
               end
               CCRB_OP_MOVE_TO_DEVICE, CCRB_OP_MOVE_FROM_DEVICE: begin
                  resp_priv_fault <= user_mode; // RULE_05
                  if (!user_mode && op_kind == CCRB_OP_MOVE_FROM_DEVICE) begin
                     resp_data <= dcr_rd_data;
                  end
               end
               CCRB_OP_MOVE_FROM_COND: begin
                  resp_data <= cond_reg;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Device control registers live outside; forward only privileged accesses
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dcr_req <= 1'b0;
         dcr_write <= 1'b0;
         dcr_number <= 10'h000;
         dcr_wdata <= 32'h00000000;
      end else begin
         dcr_req <= op_valid && !user_mode && (op_kind == CCRB_OP_MOVE_TO_DEVICE ||
                    op_kind == CCRB_OP_MOVE_FROM_DEVICE); // RULE_05
         dcr_write <= op_valid && !user_mode && op_kind == CCRB_OP_MOVE_TO_DEVICE;
         dcr_number <= reg_number;
         dcr_wdata <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_cfg_reserved_zero;
      (cfg_reg & ~CCRB_CFG_WRITE_MASK) == 32'h00000000;
   endproperty
   a_cfg_reserved_zero: assert property (p_cfg_reserved_zero) // RULE_20
      else $error("reserved configuration bits not zero");

   property p_tb_low_read;
      op_valid && op_kind == CCRB_OP_MOVE_FROM_TB && reg_field == 10'h188
         |=> resp_valid && !resp_bad_number && resp_data == $past(time_base[31:0]);
   endproperty
   a_tb_low_read: assert property (p_tb_low_read) // RULE_04
      else $error("low time base half not returned");

   property p_tb_high_read;
      op_valid && op_kind == CCRB_OP_MOVE_FROM_TB && reg_field == 10'h1A8
         |=> resp_valid && !resp_bad_number && resp_data == $past(time_base[63:32]);
   endproperty
   a_tb_high_read: assert property (p_tb_high_read) // RULE_03
      else $error("high time base half not returned");

   property p_tb_user_ok;
      op_valid && op_kind == CCRB_OP_MOVE_FROM_TB && user_mode
         |=> !resp_priv_fault && $stable(cfg_reg) && $stable(cond_reg);
   endproperty
   a_tb_user_ok: assert property (p_tb_user_ok) // RULE_02
      else $error("time base read faulted or wrote state");

   property p_dcr_privileged;
      op_valid && user_mode && (op_kind == CCRB_OP_MOVE_TO_DEVICE ||
         op_kind == CCRB_OP_MOVE_FROM_DEVICE) |=> resp_priv_fault && !dcr_req;
   endproperty
   a_dcr_privileged: assert property (p_dcr_privileged) // RULE_05
      else $error("user device control access not refused");

   property p_cfg_user_blocked;
      op_valid && user_mode && op_kind == CCRB_OP_MOVE_TO_SPECIAL && hit_core_cfg
         |=> $stable(cfg_reg) && resp_priv_fault;
   endproperty
   a_cfg_user_blocked: assert property (p_cfg_user_blocked) // configuration write is privileged
      else $error("user write changed configuration");

   property p_data_prio;
      ##1 data_bus_priority == {$past(cfg_reg[CCRB_DATA_PRIO1_POS]), $past(data_prio_dyn)};
   endproperty
   a_data_prio: assert property (p_data_prio) // RULE_09
      else $error("data bus priority mismatch");

   property p_count_dec;
      loop_dec && !count_write |=> loop_count == $past(loop_count) - 32'h00000001;
   endproperty
   a_count_dec: assert property (p_count_dec) // RULE_19
      else $error("count did not decrement");

   property p_cond_field0;
      cond_write && cond_field_mask[0] |=> condition_fields[31:28] == $past(wr_data[31:28]);
   endproperty
   a_cond_field0: assert property (p_cond_field0) // RULE_18
      else $error("condition field 0 not written at top nibble");

   property p_prefetch_write;
      cfg_write |=> prefetch_cachable == $past(wr_data[CCRB_PREFETCH_CACH_POS])
         && fetch_no_allocate == $past(wr_data[CCRB_FETCH_NO_ALLOC_POS]);
   endproperty
   a_prefetch_write: assert property (p_prefetch_write) // RULE_13
      else $error("configuration field not captured");

   property p_cov_tb_read;
      op_valid && op_kind == CCRB_OP_MOVE_FROM_TB && hit_tb_high;
   endproperty
   c_tb_read: cover property (p_cov_tb_read);

   property p_cov_cfg_write;
      cfg_write ##1 load_full_line;
   endproperty
   c_cfg_write: cover property (p_cov_cfg_write);

   property p_cov_dcr;
      dcr_req && dcr_write;
   endproperty
   c_dcr: cover property (p_cov_dcr);

endmodule // ccrb_core_config_bank
`default_nettype wire

// ===== dv/ccrb_core_config_bank_tb.sv
// Self-checking testbench of the core configuration register bank
`timescale 1ns/1ps
`default_nettype none
module ccrb_core_config_bank_tb;
   import ccrb_pkg::*;

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   ccrb_op_type op_kind = CCRB_OP_NONE;
   logic user_mode = 1'b0;
   logic [9:0] reg_field = 10'h000;
   logic [31:0] wr_data = 32'h00000000;
   logic [7:0] cond_field_mask = 8'h00;
   logic [63:0] time_base = 64'h0000000000000000;
   logic [31:0] dcr_rd_data = 32'h00000000;
   logic loop_dec = 1'b0;
   logic data_prio_dyn = 1'b0;
   logic resp_valid, resp_priv_fault, resp_bad_number, dcr_req, dcr_write;
   logic [31:0] resp_data, dcr_wdata, core_configuration, condition_fields, loop_count;
   logic [9:0] dcr_number;
   logic [1:0] data_bus_priority, instr_bus_priority;
   logic load_full_line, load_no_allocate, store_no_allocate, user_attr_exception_enable;
   logic load_debug_visible, prefetch_cachable, prefetch_noncachable, noncachable_fetch_size;
   logic fetch_no_allocate, cache_info_select, cache_way_select;
   logic [31:0] r_data, r_flags, r_wd;
   logic [9:0] r_num;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;

   ccrb_core_config_bank ccrb_core_config_bank_i (.core_clk(core_clk), .rst(rst),
      .op_valid(op_valid), .op_kind(op_kind), .user_mode(user_mode), .reg_field(reg_field),
      .wr_data(wr_data), .cond_field_mask(cond_field_mask), .time_base(time_base),
      .dcr_rd_data(dcr_rd_data), .loop_dec(loop_dec), .data_prio_dyn(data_prio_dyn),
      .resp_valid(resp_valid), .resp_data(resp_data), .resp_priv_fault(resp_priv_fault),
      .resp_bad_number(resp_bad_number), .dcr_req(dcr_req), .dcr_write(dcr_write),
      .dcr_number(dcr_number), .dcr_wdata(dcr_wdata), .core_configuration(core_configuration),
      .load_full_line(load_full_line), .load_no_allocate(load_no_allocate),
      .store_no_allocate(store_no_allocate), .data_bus_priority(data_bus_priority),
      .instr_bus_priority(instr_bus_priority),
      .user_attr_exception_enable(user_attr_exception_enable),
      .load_debug_visible(load_debug_visible), .prefetch_cachable(prefetch_cachable),
      .prefetch_noncachable(prefetch_noncachable),
      .noncachable_fetch_size(noncachable_fetch_size), .fetch_no_allocate(fetch_no_allocate),
      .cache_info_select(cache_info_select), .cache_way_select(cache_way_select),
      .condition_fields(condition_fields), .loop_count(loop_count));

   always #20 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Run is about 85 cycles; the ceiling leaves ample slack
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         $display("MISMATCH at %0t: cycle limit reached", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // Entered at a falling edge; the answer is caught at the next falling edge, half a cycle after the take
   task automatic op(input ccrb_op_type k, input logic [9:0] f, input logic [31:0] d,
                     input logic u);
      op_valid = 1'b1;
      op_kind = k;
      reg_field = f;
      wr_data = d;
      user_mode = u;
      @(negedge core_clk);
      r_data = resp_data;
      r_flags = {27'h0, resp_valid, resp_priv_fault, resp_bad_number, dcr_req, dcr_write};
      r_num = dcr_number;
      r_wd = dcr_wdata;
      op_valid = 1'b0;
      op_kind = CCRB_OP_NONE;
      @(negedge core_clk);
   endtask

   // Field outputs placed at big-endian positions n -> [31-n]
   function automatic logic [31:0] cfg_view();
      logic [31:0] o;
      o = 32'h00000000;
      o[31-6] = load_full_line;
      o[31-7] = load_no_allocate;
      o[31-8] = store_no_allocate;
      o[31-9] = data_bus_priority[1];
      o[31-10] = instr_bus_priority[1];
      o[31-11] = instr_bus_priority[0];
      o[31-14] = user_attr_exception_enable;
      o[31-15] = load_debug_visible;
      o[31-20] = prefetch_cachable;
      o[31-21] = prefetch_noncachable;
      o[31-22] = noncachable_fetch_size;
      o[31-23] = fetch_no_allocate;
      o[31-27] = cache_info_select;
      o[31-31] = cache_way_select;
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(core_configuration, 32'h00000000, "config reset");
      chk(loop_count, 32'h00000000, "count reset");
      chk(condition_fields, 32'h00000000, "condition reset");
   endtask

   task automatic t_config();
      int bits [14] = '{6, 7, 8, 9, 10, 11, 14, 15, 20, 21, 22, 23, 27, 31};
      logic [31:0] m;
      logic [31:0] e;
      logic [31:0] x;
      m = 32'h00000000;
      foreach (bits[i]) begin
         e = 32'h00000001 << (31 - bits[i]);
         m = m | e;
         op(CCRB_OP_MOVE_TO_SPECIAL, 10'h27D, e, 1'b0);
         chk(core_configuration, e, "config single bit");
         x = cfg_view() ^ e;
         chk({24'h0, x[31:24]}, 32'h00000000, "fields 0-7");
         chk({24'h0, x[23:16]}, 32'h00000000, "fields 8-15");
         chk({24'h0, x[15:8]}, 32'h00000000, "fields 16-23");
         chk({24'h0, x[7:0]}, 32'h00000000, "fields 24-31");
      end
      op(CCRB_OP_MOVE_TO_SPECIAL, 10'h27D, 32'hFFFFFFFF, 1'b0);
      chk(core_configuration, m, "all ones masked");
      op(CCRB_OP_MOVE_FROM_SPECIAL, 10'h27D, 32'h00000000, 1'b0);
      chk(r_data, m, "config readback");
      op(CCRB_OP_MOVE_TO_SPECIAL, 10'h27D, 32'h00000000, 1'b1);
      chk(r_flags, 32'h00000018, "user config write refused");
      chk(core_configuration, m, "user config write ignored");
      op(CCRB_OP_MOVE_FROM_SPECIAL, 10'h27D, 32'h00000000, 1'b1);
      chk(r_data, 32'h00000000, "user config read hidden");
      chk(r_flags, 32'h00000018, "user config read refused");
      op(CCRB_OP_MOVE_TO_SPECIAL, 10'h27D, ~m, 1'b0);
      chk(core_configuration, 32'h00000000, "reserved only");
   endtask

   task automatic t_time_base();
      time_base = 64'h89ABCDEF01234567;
      op(CCRB_OP_MOVE_FROM_TB, 10'h188, 32'h00000000, 1'b1);
      chk(r_data, 32'h01234567, "low half");
      chk(r_flags, 32'h00000010, "user read allowed");
      op(CCRB_OP_MOVE_FROM_TB, 10'h1A8, 32'h00000000, 1'b1);
      chk(r_data, 32'h89ABCDEF, "high half");
      op(CCRB_OP_MOVE_TO_SPECIAL, 10'h188, 32'h5A5A5A5A, 1'b0);
      chk(r_flags, 32'h00000014, "no write on read path");
      op(CCRB_OP_MOVE_FROM_TB, 10'h120, 32'h00000000, 1'b1);
      chk(r_flags, 32'h00000014, "unknown time base number");
   endtask

   task automatic t_device();
      op(CCRB_OP_MOVE_TO_DEVICE, 10'h123, 32'hA5A55A5A, 1'b1);
      chk(r_flags, 32'h00000018, "user device write");
      op(CCRB_OP_MOVE_FROM_DEVICE, 10'h123, 32'h00000000, 1'b1);
      chk(r_flags, 32'h00000018, "user device read");
      op(CCRB_OP_MOVE_TO_DEVICE, 10'h123, 32'hA5A55A5A, 1'b0);
      chk(r_flags, 32'h00000013, "device write forwarded");
      chk({22'h0, r_num}, 32'h00000069, "device number swapped");
      chk(r_wd, 32'hA5A55A5A, "device write data");
      dcr_rd_data = 32'h3C3CC3C3;
      op(CCRB_OP_MOVE_FROM_DEVICE, 10'h3FF, 32'h00000000, 1'b0);
      chk(r_flags, 32'h00000012, "device read forwarded");
      chk(r_data, 32'h3C3CC3C3, "device read data");
   endtask

   task automatic t_cond();
      cond_field_mask = 8'h01;
      op(CCRB_OP_MOVE_TO_COND, 10'h000, 32'hFFFFFFFF, 1'b1);
      chk(condition_fields, 32'hF0000000, "field 0 at top");
      cond_field_mask = 8'h80;
      op(CCRB_OP_MOVE_TO_COND, 10'h000, 32'h12345678, 1'b1);
      chk(condition_fields, 32'hF0000008, "field 7 at bottom");
      cond_field_mask = 8'h3C;
      op(CCRB_OP_MOVE_TO_COND, 10'h000, 32'h12345678, 1'b1);
      op(CCRB_OP_MOVE_FROM_COND, 10'h000, 32'h00000000, 1'b1);
      chk(r_data, 32'hF0345608, "fields 2 to 5");
   endtask

   task automatic t_count();
      op(CCRB_OP_MOVE_TO_SPECIAL, 10'h120, 32'h00000001, 1'b1);
      chk(loop_count, 32'h00000001, "count write");
      for (int i = 0; i < 2; i++) begin
         loop_dec = 1'b1;
         @(negedge core_clk);
         loop_dec = 1'b0;
         @(negedge core_clk);
      end
      chk(loop_count, 32'hFFFFFFFF, "count wraps over 32 bits");
      op(CCRB_OP_MOVE_FROM_SPECIAL, 10'h120, 32'h00000000, 1'b1);
      chk(r_data, 32'hFFFFFFFF, "count readback");
   endtask

   task automatic t_prio();
      data_prio_dyn = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({31'h0, data_bus_priority[0]}, 32'h00000001, "dynamic bit set");
      data_prio_dyn = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({31'h0, data_bus_priority[0]}, 32'h00000000, "dynamic bit clear");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_config();
      t_time_base();
      t_device();
      t_cond();
      t_count();
      t_prio();
      test_done();
   end

endmodule // ccrb_core_config_bank_tb
`default_nettype wire
